// ### verilog/timer_regs.vh
// ****************************************************************
// register map of the timer, offsets are byte addresses
// ****************************************************************
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ****************************************************************
// offsets
// ****************************************************************
`define OFS_CTRL    8'h00
`define OFS_COUNT   8'h04
`define OFS_PRESC   8'h08
`define OFS_PCOUNT  8'h0C
`define OFS_MCTRL   8'h10
`define OFS_CCTRL   8'h14
`define OFS_OCTRL   8'h18
`define OFS_STATUS  8'h1C
`define OFS_MASK    8'h20
`define OFS_OSTATE  8'h24
`define OFS_MATCH0  8'h30
`define OFS_CAP0    8'h40

// ****************************************************************
// control fields
// ****************************************************************
`define CTRL_EN     0
`define CTRL_CLR    1
`define CTRL_CNT    2
`define CTRL_SRC    3
`define CTRL_EDGE   5
`define CTRL_W      7

// per channel fields, channel i starts at bit 3*i
`define MC_INT      0
`define MC_RST      1
`define MC_STOP     2
`define CC_RISE     0
`define CC_FALL     1
`define CC_INT      2

// ****************************************************************
// reset values and responses
// ****************************************************************
`define CTRL_RST    7'h00
`define WORD_RST    32'h0000_0000
`define FLAG_RST    8'h00
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// three stage pin synchroniser with agreement filter
// ****************************************************************
module pin_sync (
    input  wire       clk,
    input  wire       rst,
    input  wire [3:0] d,
    output reg  [3:0] q
);

    reg [3:0] s1_r;  // metastable stage, read only by s2
    reg [3:0] s2_r;  // second stage
    reg [3:0] s3_r;  // third stage

    // shift pins in; take a level once stages two and three agree
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            q    <= 4'h0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // bitwise: agreeing bits follow, the others hold
            q    <= (q & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        end
    end

endmodule // pin_sync

`default_nettype wire

// ### verilog/axil_port.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"

// ****************************************************************
// axi4-lite slave handshake, one write and one read at a time
// ****************************************************************
module axil_port (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        wr_en,
    output reg  [7:0]  wr_addr,
    output reg  [31:0] wr_data,
    output reg  [3:0]  wr_strb,
    input  wire        wr_ok,
    output wire [7:0]  rd_addr,
    input  wire [31:0] rd_data,
    input  wire        rd_ok
);

    reg aw_full_r;  // write address held
    reg w_full_r;   // write data held

    // both halves held and no response pending
    assign wr_en   = aw_full_r & w_full_r & ~s_axi_bvalid;
    assign rd_addr = s_axi_araddr;

    // ************************************************************
    // write channels
    // ************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            wr_addr       <= 8'h00;
            wr_data       <= `WORD_RST;
            wr_strb       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            // address taken, hold it
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r     <= 1'b1;
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // data taken, hold it
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r     <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // write performed, answer
            if (wr_en) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            // answer taken, reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // read channels
    // ************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `WORD_RST;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            // unmapped reads return zero with an error
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? rd_data : `WORD_RST;
            s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // axil_port

`default_nettype wire

// ### verilog/timer_capture_match.v
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"

module timer_capture_match (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [3:0]  cap_in,
    output wire [3:0]  match_out,
    output wire        irq
);

    // ************************************************************
    // helpers
    // ************************************************************

    // byte lane merge of a write into a word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge[8*b +: 8] = nw[8*b +: 8];
        end
    endfunction

    // mapped register offsets
    function mapped;
        input [7:0] a;
        begin
            mapped = (a <= `OFS_OSTATE && a[1:0] == 2'b00) ||
                     (a[7:4] == `OFS_MATCH0 >> 4 && a[1:0] == 2'b00) ||
                     (a[7:4] == `OFS_CAP0 >> 4 && a[1:0] == 2'b00);
        end
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    reg [`CTRL_W-1:0] ctrl_r;         // enable, clear, mode, source
    reg [31:0]        tc_r;           // main count
    reg [31:0]        pr_r;           // prescale limit
    reg [31:0]        pc_r;           // prescale count
    reg [11:0]        mctl_r;         // match actions
    reg [11:0]        cctl_r;         // capture edges and irq
    reg [7:0]         octl_r;         // output actions
    reg [7:0]         stat_r;         // sticky event flags
    reg [7:0]         mask_r;         // interrupt mask
    reg [3:0]         mout_r;         // match output pins
    reg [3:0]         prev_r;         // last filtered capture level
    reg               irq_r;          // interrupt output
    reg [31:0]        match_r [0:3];  // match values
    reg [31:0]        cap_r   [0:3];  // captured counts

    wire [3:0]  cap_s;    // filtered capture pins
    wire        wr_en;    // write strobe
    wire [7:0]  wr_addr;  // write address
    wire [31:0] wr_data;  // write data
    wire [3:0]  wr_strb;  // write lanes
    wire [7:0]  rd_addr;  // read address
    reg  [31:0] rd_data;  // read mux
    // merged write words, cut to width where taken
    wire [31:0] ctrl_wr = merge({25'h0, ctrl_r}, wr_data, wr_strb);
    wire [31:0] mctl_wr = merge({20'h0, mctl_r}, wr_data, wr_strb);
    wire [31:0] cctl_wr = merge({20'h0, cctl_r}, wr_data, wr_strb);

    // combinational results
    reg [3:0]  rise;      // rising edges
    reg [3:0]  fall;      // falling edges
    reg        src_edge;  // counter mode event
    reg        step;      // prescaler advance
    reg        tick;      // count advance
    reg [3:0]  mhit;      // match events
    reg [3:0]  cevt;      // capture events
    reg [7:0]  ev;        // flags to set
    reg        do_rst;    // some match resets
    reg        do_stop;   // some match stops
    reg [3:0]  mout_nxt;  // output pins next
    reg [7:0]  stat_nxt;  // flags next
    integer    i;
    integer    j;         // loop index, clocked side

    assign match_out = mout_r;
    assign irq       = irq_r;

    // ************************************************************
    // submodules
    // ************************************************************

    // capture pins come from outside the clock domain
    pin_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (cap_in),
        .q   (cap_s)
    );

    // register bus
    axil_port u_bus (
        .clk           (clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (mapped(wr_addr)),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (mapped(rd_addr))
    );

    // ************************************************************
    // event logic
    // ************************************************************

    // edges, prescaler tick, matches, captures, pin actions
    always @* begin
        rise = cap_s & ~prev_r;
        fall = ~cap_s & prev_r;
        // pick edge source in counter mode
        src_edge = (ctrl_r[`CTRL_EDGE] & rise[ctrl_r[`CTRL_SRC +: 2]]) |
                   (ctrl_r[`CTRL_EDGE+1] & fall[ctrl_r[`CTRL_SRC +: 2]]);
        step = ctrl_r[`CTRL_EN] & ~ctrl_r[`CTRL_CLR] &
               (ctrl_r[`CTRL_CNT] ? src_edge : 1'b1);
        tick = step && (pc_r == pr_r);
        do_rst   = 1'b0;
        do_stop  = 1'b0;
        mout_nxt = mout_r;
        for (i = 0; i < 4; i = i + 1) begin
            // match judged on the prescaled tick only
            mhit[i] = tick && (tc_r == match_r[i]);
            do_rst  = do_rst | (mhit[i] & mctl_r[3*i + `MC_RST]);
            do_stop = do_stop | (mhit[i] & mctl_r[3*i + `MC_STOP]);
            cevt[i] = (cctl_r[3*i + `CC_RISE] & rise[i]) |
                      (cctl_r[3*i + `CC_FALL] & fall[i]);
            // match flag if its irq is enabled
            ev[i]   = mhit[i] & mctl_r[3*i + `MC_INT];
            // capture flag only with its own enable
            ev[4+i] = cevt[i] & cctl_r[3*i + `CC_INT];
            if (mhit[i]) begin
                case (octl_r[2*i +: 2])
                    2'h1:    mout_nxt[i] = 1'b0;
                    2'h2:    mout_nxt[i] = 1'b1;
                    2'h3:    mout_nxt[i] = ~mout_r[i];
                    default: mout_nxt[i] = mout_r[i];
                endcase
            end
        end
        stat_nxt = stat_r;
        if (wr_en && wr_addr == `OFS_STATUS && wr_strb[0])
            stat_nxt = stat_nxt & ~wr_data[7:0];
        stat_nxt = stat_nxt | ev;
    end

    // ************************************************************
    // read mux
    // ************************************************************

    // registers seen by software
    always @* begin
        case (rd_addr)
            `OFS_CTRL:   rd_data = {25'h0, ctrl_r};
            `OFS_COUNT:  rd_data = tc_r;
            `OFS_PRESC:  rd_data = pr_r;
            `OFS_PCOUNT: rd_data = pc_r;
            `OFS_MCTRL:  rd_data = {20'h0, mctl_r};
            `OFS_CCTRL:  rd_data = {20'h0, cctl_r};
            `OFS_OCTRL:  rd_data = {24'h0, octl_r};
            `OFS_STATUS: rd_data = {24'h0, stat_r};
            `OFS_MASK:   rd_data = {24'h0, mask_r};
            `OFS_OSTATE: rd_data = {28'h0, mout_r};
            default: begin
                if (rd_addr[7:4] == (`OFS_MATCH0 >> 4))
                    rd_data = match_r[rd_addr[3:2]];
                else if (rd_addr[7:4] == (`OFS_CAP0 >> 4))
                    rd_data = cap_r[rd_addr[3:2]];
                else
                    rd_data = `WORD_RST;
            end
        endcase
    end

    // ************************************************************
    // counter and prescaler
    // ************************************************************

    // count, prescale and control register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `CTRL_RST;
            tc_r   <= `WORD_RST;
            pc_r   <= `WORD_RST;
            pr_r   <= `WORD_RST;
        end else begin
            if (wr_en && wr_addr == `OFS_CTRL)
                ctrl_r <= ctrl_wr[`CTRL_W-1:0];
            if (wr_en && wr_addr == `OFS_PRESC)
                pr_r <= merge(pr_r, wr_data, wr_strb);
            if (ctrl_r[`CTRL_CLR]) begin
                // held at zero while clear bit set
                tc_r <= `WORD_RST;
                pc_r <= `WORD_RST;
            end else if (tick) begin
                pc_r <= `WORD_RST;
                // back to zero on reset match
                if (do_rst)
                    tc_r <= `WORD_RST;
                else if (!do_stop)
                    tc_r <= tc_r + 32'h0000_0001;
            end else if (step) begin
                pc_r <= pc_r + 32'h0000_0001;
            end
            if (do_stop)
                ctrl_r[`CTRL_EN] <= 1'b0;
        end
    end

    // ************************************************************
    // configuration, match and capture registers
    // ************************************************************

    // software settings and captured snapshots
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mctl_r <= 12'h000;
            cctl_r <= 12'h000;
            octl_r <= 8'h00;
            mask_r <= `FLAG_RST;
            prev_r <= 4'h0;
            for (j = 0; j < 4; j = j + 1) begin
                match_r[j] <= `WORD_RST;
                cap_r[j]   <= `WORD_RST;
            end
        end else begin
            prev_r <= cap_s;
            if (wr_en && wr_addr == `OFS_MCTRL)
                mctl_r <= mctl_wr[11:0];
            if (wr_en && wr_addr == `OFS_CCTRL)
                cctl_r <= cctl_wr[11:0];
            if (wr_en && wr_addr == `OFS_OCTRL && wr_strb[0])
                octl_r <= wr_data[7:0];
            if (wr_en && wr_addr == `OFS_MASK && wr_strb[0])
                mask_r <= wr_data[7:0];
            for (j = 0; j < 4; j = j + 1) begin
                // match value writes
                if (wr_en && wr_addr == `OFS_MATCH0 + 8'h04 * j)
                    match_r[j] <= merge(match_r[j], wr_data, wr_strb);
                // snapshot the count on capture edge
                if (cevt[j])
                    cap_r[j] <= tc_r;
            end
        end
    end

    // ************************************************************
    // flags, pins, interrupt
    // ************************************************************

    // sticky status, match pins and masked interrupt
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_r <= `FLAG_RST;
            mout_r <= 4'h0;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            // software may preset pins; a match overrides
            if (wr_en && wr_addr == `OFS_OSTATE && wr_strb[0])
                mout_r <= (wr_data[3:0] & ~mhit) | (mout_nxt & mhit);
            else
                mout_r <= mout_nxt;
            irq_r <= |(stat_nxt & mask_r);
        end
    end

endmodule // timer_capture_match

`default_nettype wire

// ### testbench/timer_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"
// ****************************************
// bus and interrupt properties at the pins
// ****************************************
module timer_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // address and data taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_block: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not blocked");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid ##0 s_axi_awready) else $error("write answer stuck");
    a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read answer stuck");
    a_rd_unmapped: assert property (s_rd_take ##0 s_axi_araddr == 8'hFC |=>
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_irq_mask: assert property (
        s_wr_take ##0 (s_axi_awaddr == `OFS_MASK && s_axi_wdata == 32'h0)
        |-> ##3 !irq) else $error("masked interrupt still high");
endmodule // timer_props

bind timer_capture_match timer_props u_props (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ### testbench/cap_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// outside sources on the capture pins
// ****************************************
module cap_pins (
    input  wire logic       clk,
    output var  logic [3:0] cap_in
);
    // pins idle low
    initial cap_in = 4'h0;
    // one clean pulse, four cycles high and low, beats the filter
    task automatic pulse(input int ch);
        @(posedge clk);
        cap_in[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        cap_in[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // cap_pins
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"
// ****************************************
// timer bench
// ****************************************
module tb;
    logic        clk = 0;         // 25 MHz clock
    logic        rst = 1;         // reset
    logic [7:0]  awaddr = 0;      // write address
    logic [7:0]  araddr = 0;      // read address
    logic [31:0] wdata = 0;       // write data
    logic        awvalid = 0;     // address valid
    logic        wvalid = 0;      // data valid
    logic        arvalid = 0;     // read valid
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp;    // responses
    wire  [31:0] rdata;           // read data
    wire  [3:0]  cap_in, match_out;
    logic [31:0] v;               // last read
    integer      num_errors = 0;  // mismatches
    integer      comparisons = 0; // checks
    integer      seed = 32'h0991; // random seed
    integer      i, k, n;         // loop and count
    int unsigned mdl [int];       // model of written words

    timer_capture_match uut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .cap_in(cap_in), .match_out(match_out),
        .irq(irq));
    cap_pins u_pins (.clk(clk), .cap_in(cap_in));

    // clock and reset
    initial forever #20 clk = ~clk;
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
    end
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // bounded wait ends the run when used up
    task lim(input integer kk, input integer m);
        check("wait_bound", kk < m, 1);
        if (kk >= m) stop_test();
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        lim(k, 50);
        check("bresp", bresp, r);
    endtask
    task rd(input [7:0] a, input [1:0] r);
        araddr <= a;
        arvalid <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        lim(k, 50);
        v = rdata;
        check("rresp", rresp, r);
    endtask
    task rchk(input string nm, input [7:0] a, input [31:0] e);
        rd(a, `RESP_OKAY);
        check(nm, v, e);
    endtask
    task wirq;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (irq === 1'b1) break;
        end
        lim(k, 300);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rchk("ctrl", `OFS_CTRL, `WORD_RST);
        rd(8'hFC, `RESP_SLVERR);
        check("unmapped", v, 0);
        wr(8'hFC, 32'hFFFF_FFFF, `RESP_SLVERR);
        for (i = 0; i < 4; i++) begin
            mdl[i] = $random(seed);
            wr(`OFS_MATCH0 + 8'(4 * i), mdl[i], `RESP_OKAY);
        end
        for (i = 0; i < 4; i++) begin
            rchk("match", `OFS_MATCH0 + 8'(4 * i), mdl[i]);
            wr(`OFS_MATCH0 + 8'(4 * i), 5, `RESP_OKAY);
        end
        // pins: toggle, high, low, hold; reset on match 0
        wr(`OFS_OSTATE, 32'h0C, `RESP_OKAY);
        check("pins", match_out, 4'hC);
        wr(`OFS_OCTRL, 32'h1B, `RESP_OKAY);
        wr(`OFS_MCTRL, 32'h03, `RESP_OKAY);
        wr(`OFS_MASK, 32'h01, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h01, `RESP_OKAY);
        wirq();
        check("pins", match_out, 4'hB);
        for (i = 0; i < 3; i++) begin
            rd(`OFS_COUNT, `RESP_OKAY);
            check("count_wrap", v <= 5, 1);
        end
        wr(`OFS_CTRL, 32'h00, `RESP_OKAY);
        rchk("status", `OFS_STATUS, 32'h01);
        wr(`OFS_MASK, 32'h00, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check("irq", irq, 0);
        wr(`OFS_MASK, 32'h01, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check("irq", irq, 1);
        wr(`OFS_STATUS, 32'h01, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check("irq", irq, 0);
        rchk("status", `OFS_STATUS, 32'h00);
        // stop on match 1 at count 3, prescale by three
        wr(`OFS_MCTRL, 32'h28, `RESP_OKAY);
        wr(`OFS_MATCH0 + 8'h04, 3, `RESP_OKAY);
        wr(`OFS_PRESC, 2, `RESP_OKAY);
        wr(`OFS_MASK, 32'h02, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h02, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h01, `RESP_OKAY);
        wirq();
        check("presc_delay", k >= 9 && k <= 18, 1);
        rchk("ctrl", `OFS_CTRL, 32'h00);
        rchk("status", `OFS_STATUS, 32'h02);
        rchk("count_stop", `OFS_COUNT, 3);
        repeat (10) @(posedge clk);
        rchk("count_hold", `OFS_COUNT, 3);
        wr(`OFS_STATUS, 32'h02, `RESP_OKAY);
        // count rising edges of pin 0 prescaled by two, capture on pin 1
        wr(`OFS_MCTRL, 32'h00, `RESP_OKAY);
        wr(`OFS_MASK, 32'h20, `RESP_OKAY);
        wr(`OFS_CCTRL, 32'h38, `RESP_OKAY);
        wr(`OFS_PRESC, 1, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h02, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h25, `RESP_OKAY);
        n = 1 + ($random(seed) & 3);
        for (i = 0; i < 2 * n; i++) u_pins.pulse(0);
        u_pins.pulse(1);
        wirq();
        rchk("count", `OFS_COUNT, n);
        rchk("cap1", `OFS_CAP0 + 8'h04, n);
        rchk("cap0", `OFS_CAP0, 0);
        rchk("status", `OFS_STATUS, 32'h20);
        stop_test();
    end
endmodule // tb
`default_nettype wire
